// ---- dps_top.sv ----
// dps_top: two pulse/serial channels, shared 64-word fifo, AXI4-Lite registers.
// assumes one aclk domain; pwm_out drives pins directly.
// Operation
// - two independent channels, each selects modulation or serialiser mode
// - both modes run on the one modulator clock
// - shared fifo of sixty-four 32-bit words fed by the fifo port
// - N ones in M cycles, spread as evenly as possible
// - spread mode uses the word as N and period as M
// - mark/space mode bypasses spreading; mark is the word, period is period
// - modulation sends while data register source, or fifo source not empty
// - serialiser shifts word msb first within the period
// - short period truncates, long period pads; period resets to 32
// - channel_on starts a channel; registers and fifo always writable
// - mode bit zero selects modulation, one selects serialiser
// - mark_space_select chooses mark/space, ignored in serialiser mode
// - repeat_last_word resends last fifo word on empty, else stop
// - idle_level drives output when idle and pads serial periods
// - output_invert inverts the final output
// - fifo_source_select picks fifo when one, channel_word when zero
// - writing one to fifo_flush empties fifo; bit reads zero
// - control layout: channel 1 low byte, channel 2 next byte
// - shared fifo words alternate between channels, channel 1 first
//
// Local design decision: the AXI4-Lite interface to the registers.
`default_nettype none
module dps_top (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [7:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic [1:0] pwm_out
);
   dps_pkg::dps_cfg_type cfg_reg [2];
   logic [31:0] per_reg [2];
   logic [31:0] word_reg [2];
   logic [31:0] dma_reg;
   logic [31:0] fifo_mem [dps_pkg::DPS_FIFO_DEPTH];
   logic [5:0] rd_ptr_reg;
   logic [5:0] wr_ptr_reg;
   logic [6:0] count_reg;
   logic werr_reg;
   logic rerr_reg;
   logic [1:0] gap_reg;
   logic turn_reg;
   dps_pkg::dps_state_type st_reg [2];
   logic [31:0] pos_reg [2];
   logic [31:0] acc_reg [2];
   logic [31:0] cur_reg [2];
   logic [1:0] have_last_reg;
   logic [7:0] aw_addr_reg;
   logic [31:0] wd_reg;
   logic [3:0] ws_reg;
   logic wr_go_c;
   logic flush_c;
   logic push_c;
   logic pop_c;
   logic empty_c;
   logic full_c;
   logic share_c;
   logic [31:0] head_c;
   logic [1:0] req_c;
   logic [1:0] grant_c;
   logic [1:0] ok_c;
   logic [1:0] lost_c;
   logic [31:0] w_c [2];
   dps_pkg::dps_step_type step_c [2];
   logic [31:0] rd_c;
   logic [31:0] stat_c;

   // byte-lane merge of a register write
   function automatic logic [31:0] dps_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // address decode shared by read and write paths
   function automatic logic dps_mapped(input logic [7:0] a);
      return a == dps_pkg::DPS_OFF_CTRL || a == dps_pkg::DPS_OFF_STAT ||
         a == dps_pkg::DPS_OFF_DMA || a == dps_pkg::DPS_OFF_PER1 ||
         a == dps_pkg::DPS_OFF_WORD1 || a == dps_pkg::DPS_OFF_FIFO ||
         a == dps_pkg::DPS_OFF_PER2 || a == dps_pkg::DPS_OFF_WORD2;
   endfunction

   // one output bit of a channel for word w at period position pos
   function automatic dps_pkg::dps_step_type dps_step(input dps_pkg::dps_cfg_type c,
         input logic [31:0] w, input logic [31:0] pos, input logic [31:0] acc,
         input logic [31:0] per);
      dps_pkg::dps_step_type s;
      logic [32:0] sum;
      s.acc = acc;
      sum = {1'b0, acc} + {1'b0, w};
      if (c.mode) begin
         // msb first; positions past the word carry the idle level
         s.bit_out = (pos < dps_pkg::DPS_SER_LEN) ? w[~pos[4:0]] : c.idle;
      end else if (c.ms) begin
         s.bit_out = pos < w;
      end else if (sum >= {1'b0, per}) begin
         s.bit_out = 1'b1;
         s.acc = 32'(sum - {1'b0, per});
      end else begin
         s.bit_out = 1'b0;
         s.acc = sum[31:0];
      end
      return s;
   endfunction

   // write commits once both address and data are held
   assign wr_go_c = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   assign flush_c = wr_go_c && aw_addr_reg == dps_pkg::DPS_OFF_CTRL && ws_reg[0] &&
      wd_reg[dps_pkg::DPS_FLUSH_BIT];
   assign push_c = wr_go_c && aw_addr_reg == dps_pkg::DPS_OFF_FIFO && !full_c;
   assign empty_c = count_reg == 7'h00;
   assign full_c = count_reg == dps_pkg::DPS_FIFO_FULL;
   assign head_c = fifo_mem[rd_ptr_reg];
   assign pop_c = |grant_c;

   // word source and step for each channel at this position
   always_comb begin
      share_c = cfg_reg[0].on & cfg_reg[0].fifo & cfg_reg[1].on & cfg_reg[1].fifo;
      for (int i = 0; i < dps_pkg::DPS_NCH; i++) begin
         req_c[i] = cfg_reg[i].on & cfg_reg[i].fifo & (pos_reg[i] == 32'h0);
         // when shared, only the channel whose turn it is may pop
         grant_c[i] = req_c[i] & ~empty_c & (~share_c | (turn_reg == 1'(i)));
         w_c[i] = cur_reg[i];
         ok_c[i] = 1'b1;
         lost_c[i] = 1'b0;
         if (pos_reg[i] == 32'h0) begin
            if (!cfg_reg[i].fifo) begin
               w_c[i] = word_reg[i];
            end else if (grant_c[i]) begin
               w_c[i] = head_c;
            end else if (!(cfg_reg[i].rpt & have_last_reg[i])) begin
               ok_c[i] = 1'b0;
               lost_c[i] = req_c[i] & empty_c;
            end
         end
         step_c[i] = dps_step(cfg_reg[i], w_c[i], pos_reg[i], acc_reg[i], per_reg[i]);
      end
   end

   // fifo pointers; flush wins over everything else
   always_ff @(posedge aclk) begin
      if (!aresetn || flush_c) begin
         rd_ptr_reg <= 6'h00;
         wr_ptr_reg <= 6'h00;
         count_reg <= 7'h00;
      end else begin
         if (push_c) begin
            wr_ptr_reg <= wr_ptr_reg + 6'h01;
         end
         if (pop_c) begin
            rd_ptr_reg <= rd_ptr_reg + 6'h01;
         end
         count_reg <= 7'(count_reg + {6'h00, push_c} - {6'h00, pop_c});
      end
   end

   // fifo storage, no reset needed
   always_ff @(posedge aclk) begin
      if (push_c) begin
         fifo_mem[wr_ptr_reg] <= dps_merge(32'h0, wd_reg, ws_reg);
      end
   end

   // turn for shared use; channel 1 first after any change of sharing
   always_ff @(posedge aclk) begin
      if (!aresetn || !share_c) begin
         turn_reg <= 1'b0;
      end else if (pop_c) begin
         turn_reg <= ~turn_reg;
      end
   end

   // channel units; outputs come straight from these flops
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < dps_pkg::DPS_NCH; i++) begin
            st_reg[i] <= dps_pkg::DPS_IDLE;
            pos_reg[i] <= 32'h0;
            acc_reg[i] <= 32'h0;
            cur_reg[i] <= 32'h0;
         end
         have_last_reg <= 2'h0;
         pwm_out <= 2'h0;
      end else begin
         for (int i = 0; i < dps_pkg::DPS_NCH; i++) begin
            if (grant_c[i]) begin
               have_last_reg[i] <= 1'b1;
            end else if (flush_c) begin
               have_last_reg[i] <= 1'b0;
            end
            if (!cfg_reg[i].on) begin
               st_reg[i] <= dps_pkg::DPS_IDLE;
               pos_reg[i] <= 32'h0;
               acc_reg[i] <= 32'h0;
               pwm_out[i] <= cfg_reg[i].idle ^ cfg_reg[i].inv;
            end else if (!ok_c[i]) begin
               st_reg[i] <= dps_pkg::DPS_IDLE;
               pwm_out[i] <= cfg_reg[i].idle ^ cfg_reg[i].inv;
            end else begin
               st_reg[i] <= dps_pkg::DPS_SEND;
               acc_reg[i] <= step_c[i].acc;
               pwm_out[i] <= step_c[i].bit_out ^ cfg_reg[i].inv;
               cur_reg[i] <= w_c[i];
               // period ends when pos+1 reaches period_length
               if ({1'b0, pos_reg[i]} + 33'h1 >= {1'b0, per_reg[i]}) begin
                  pos_reg[i] <= 32'h0;
               end else begin
                  pos_reg[i] <= pos_reg[i] + 32'h1;
               end
            end
         end
      end
   end

   // status events; a set in the clearing cycle wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         werr_reg <= 1'b0;
         rerr_reg <= 1'b0;
         gap_reg <= 2'h0;
      end else begin
         if (wr_go_c && aw_addr_reg == dps_pkg::DPS_OFF_STAT && ws_reg[0]) begin
            werr_reg <= werr_reg & ~wd_reg[dps_pkg::DPS_ST_WERR];
            rerr_reg <= rerr_reg & ~wd_reg[dps_pkg::DPS_ST_RERR];
            gap_reg <= gap_reg & ~wd_reg[dps_pkg::DPS_ST_GAP0 +: 2];
         end
         if (wr_go_c && aw_addr_reg == dps_pkg::DPS_OFF_FIFO && full_c) begin
            werr_reg <= 1'b1;
         end
         if (|lost_c) begin
            rerr_reg <= 1'b1;
         end
         for (int i = 0; i < dps_pkg::DPS_NCH; i++) begin
            if (lost_c[i] && st_reg[i] == dps_pkg::DPS_SEND) begin
               gap_reg[i] <= 1'b1;
            end
         end
      end
   end

   // software registers; bits 6 and 14 are never stored
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < dps_pkg::DPS_NCH; i++) begin
            cfg_reg[i] <= '0;
            per_reg[i] <= dps_pkg::DPS_PER_RST;
            word_reg[i] <= dps_pkg::DPS_WORD_RST;
         end
         dma_reg <= dps_pkg::DPS_DMA_RST;
      end else if (wr_go_c) begin
         unique case (aw_addr_reg)
            dps_pkg::DPS_OFF_CTRL: begin
               for (int i = 0; i < dps_pkg::DPS_NCH; i++) begin
                  if (ws_reg[i]) begin
                     cfg_reg[i] <= wd_reg[i*8 +: 8] & 8'hbf;
                  end
               end
            end
            dps_pkg::DPS_OFF_DMA: begin
               dma_reg <= dps_merge(dma_reg, wd_reg, ws_reg) & dps_pkg::DPS_DMA_MASK;
            end
            dps_pkg::DPS_OFF_PER1: begin
               per_reg[0] <= dps_merge(per_reg[0], wd_reg, ws_reg);
            end
            dps_pkg::DPS_OFF_WORD1: begin
               word_reg[0] <= dps_merge(word_reg[0], wd_reg, ws_reg);
            end
            dps_pkg::DPS_OFF_PER2: begin
               per_reg[1] <= dps_merge(per_reg[1], wd_reg, ws_reg);
            end
            dps_pkg::DPS_OFF_WORD2: begin
               word_reg[1] <= dps_merge(word_reg[1], wd_reg, ws_reg);
            end
            default: begin
            end
         endcase
      end
   end

   // status word and read mux
   always_comb begin
      stat_c = 32'h0;
      stat_c[dps_pkg::DPS_ST_FULL] = full_c;
      stat_c[dps_pkg::DPS_ST_EMPTY] = empty_c;
      stat_c[dps_pkg::DPS_ST_WERR] = werr_reg;
      stat_c[dps_pkg::DPS_ST_RERR] = rerr_reg;
      stat_c[dps_pkg::DPS_ST_GAP0 +: 2] = gap_reg;
      stat_c[dps_pkg::DPS_ST_BUSY0] = st_reg[0] == dps_pkg::DPS_SEND;
      stat_c[dps_pkg::DPS_ST_BUSY0 + 1] = st_reg[1] == dps_pkg::DPS_SEND;
      unique case (s_axi_araddr)
         dps_pkg::DPS_OFF_CTRL: rd_c = {16'h0, cfg_reg[1], cfg_reg[0]};
         dps_pkg::DPS_OFF_STAT: rd_c = stat_c;
         dps_pkg::DPS_OFF_DMA: rd_c = dma_reg;
         dps_pkg::DPS_OFF_PER1: rd_c = per_reg[0];
         dps_pkg::DPS_OFF_WORD1: rd_c = word_reg[0];
         dps_pkg::DPS_OFF_PER2: rd_c = per_reg[1];
         dps_pkg::DPS_OFF_WORD2: rd_c = word_reg[1];
         default: rd_c = 32'h0; // fifo port and holes read zero
      endcase
   end

   // write channels: address and data taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= dps_pkg::DPS_RESP_OKAY;
         aw_addr_reg <= 8'h00;
         wd_reg <= 32'h0;
         ws_reg <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr_reg <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wd_reg <= s_axi_wdata;
            ws_reg <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_go_c) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= dps_mapped(aw_addr_reg) ? dps_pkg::DPS_RESP_OKAY :
               dps_pkg::DPS_RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // read channel: answer the cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= dps_pkg::DPS_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_c;
         s_axi_rresp <= dps_mapped(s_axi_araddr) ? dps_pkg::DPS_RESP_OKAY :
            dps_pkg::DPS_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_flush;
      flush_c;
   endsequence
   property p_flush;
      s_flush |=> count_reg == 7'h00;
   endproperty
   a_flush: assert property (p_flush) else $error("fifo not empty after flush");

   property p_push;
      push_c && !pop_c && !flush_c |=> count_reg == 7'($past(count_reg) + 7'h01);
   endproperty
   a_push: assert property (p_push) else $error("fifo level did not grow");

   property p_turn;
      share_c && grant_c[0] |=> turn_reg;
   endproperty
   a_turn: assert property (p_turn) else $error("shared fifo turn not passed");

   property p_bresp;
      wr_go_c |=> s_axi_bvalid;
   endproperty
   a_bresp: assert property (p_bresp) else $error("write response missing");

   for (genvar g = 0; g < 2; g++) begin : g_chk
      sequence s_load;
         cfg_reg[g].on && ok_c[g] && pos_reg[g] == 32'h0;
      endsequence
      property p_off;
         (!cfg_reg[g].on)[*2] |=> st_reg[g] == dps_pkg::DPS_IDLE &&
            pwm_out[g] == $past(cfg_reg[g].idle ^ cfg_reg[g].inv);
      endproperty
      a_off: assert property (p_off) else $error("idle channel output wrong");
      property p_msb;
         s_load ##0 cfg_reg[g].mode |=> pwm_out[g] == $past(w_c[g][31] ^ cfg_reg[g].inv);
      endproperty
      a_msb: assert property (p_msb) else $error("serial word not msb first");
      property p_pad;
         cfg_reg[g].on && ok_c[g] && cfg_reg[g].mode && pos_reg[g] >= 32'h20 |=>
            pwm_out[g] == $past(cfg_reg[g].idle ^ cfg_reg[g].inv);
      endproperty
      a_pad: assert property (p_pad) else $error("serial padding not idle");
      property p_mark;
         cfg_reg[g].on && ok_c[g] && !cfg_reg[g].mode && cfg_reg[g].ms &&
            pos_reg[g] < w_c[g] |=> pwm_out[g] != $past(cfg_reg[g].inv);
      endproperty
      a_mark: assert property (p_mark) else $error("mark phase not active");
      property p_acc;
         cfg_reg[g].on && ok_c[g] && !cfg_reg[g].mode && !cfg_reg[g].ms &&
            w_c[g] <= per_reg[g] && acc_reg[g] < per_reg[g] |=> acc_reg[g] < $past(per_reg[g]);
      endproperty
      a_acc: assert property (p_acc) else $error("accumulator escaped period");
      property p_data_src;
         cfg_reg[g].on && !cfg_reg[g].fifo |=> st_reg[g] == dps_pkg::DPS_SEND;
      endproperty
      a_data_src: assert property (p_data_src) else $error("data source not sending");
      property p_stop;
         req_c[g] && empty_c && !cfg_reg[g].rpt |=> st_reg[g] == dps_pkg::DPS_IDLE;
      endproperty
      a_stop: assert property (p_stop) else $error("send on empty fifo");
      property p_repeat;
         req_c[g] && empty_c && cfg_reg[g].rpt && have_last_reg[g] |=>
            st_reg[g] == dps_pkg::DPS_SEND && cur_reg[g] == $past(cur_reg[g]);
      endproperty
      a_repeat: assert property (p_repeat) else $error("last word not repeated");
   end
endmodule
`default_nettype wire

// ---- dps_pkg.sv ----
// dps_pkg: constants and types of the two-channel pulse and serial generator.
// assumes a single aclk domain and an AXI4-Lite register port with 32-bit data.
`default_nettype none
package dps_pkg;
   // modulator clock; the logic runs on aclk, the nominal rate is kept for reference
   localparam int unsigned DPS_CLK_MHZ = 250;
   localparam int unsigned DPS_NOM_MHZ = 100;
   localparam int DPS_NCH = 2;
   localparam int DPS_FIFO_DEPTH = 64;
   localparam logic [6:0] DPS_FIFO_FULL = 7'h40;
   localparam int DPS_WORD_BITS = 32;
   // register byte offsets
   localparam logic [7:0] DPS_OFF_CTRL = 8'h00;
   localparam logic [7:0] DPS_OFF_STAT = 8'h04;
   localparam logic [7:0] DPS_OFF_DMA = 8'h08;
   localparam logic [7:0] DPS_OFF_PER1 = 8'h10;
   localparam logic [7:0] DPS_OFF_WORD1 = 8'h14;
   localparam logic [7:0] DPS_OFF_FIFO = 8'h18;
   localparam logic [7:0] DPS_OFF_PER2 = 8'h20;
   localparam logic [7:0] DPS_OFF_WORD2 = 8'h24;
   // reset values and masks
   localparam logic [31:0] DPS_PER_RST = 32'h00000020;
   localparam logic [31:0] DPS_WORD_RST = 32'h00000000;
   localparam logic [31:0] DPS_DMA_RST = 32'h00000707;
   localparam logic [31:0] DPS_DMA_MASK = 32'h8000ffff;
   localparam logic [31:0] DPS_SER_LEN = 32'h00000020;
   // control field positions
   localparam int DPS_FLUSH_BIT = 6;
   // status field positions
   localparam int DPS_ST_FULL = 0;
   localparam int DPS_ST_EMPTY = 1;
   localparam int DPS_ST_WERR = 2;
   localparam int DPS_ST_RERR = 3;
   localparam int DPS_ST_GAP0 = 4;
   localparam int DPS_ST_BUSY0 = 9;
   localparam logic [1:0] DPS_RESP_OKAY = 2'h0;
   localparam logic [1:0] DPS_RESP_SLVERR = 2'h2;
   // one channel's control byte, msb first
   typedef struct packed {
      logic ms;
      logic spare;
      logic fifo;
      logic inv;
      logic idle;
      logic rpt;
      logic mode;
      logic on;
   } dps_cfg_type;
   // one modulator step: output bit and next accumulator
   typedef struct packed {
      logic bit_out;
      logic [31:0] acc;
   } dps_step_type;
   typedef enum logic [0:0] {DPS_IDLE, DPS_SEND} dps_state_type;
endpackage
`default_nettype wire

// ---- dps_load_model.sv ----
// dps_load_model: load on the two pulse pins, counts high cycles per pin.
// assumes pwm_in is sampled on aclk; clr restarts both counts.
`default_nettype none
module dps_load_model (
   input wire logic aclk,
   input wire logic clr,
   input wire logic [1:0] pwm_in,
   output logic [15:0] ones_ch1,
   output logic [15:0] ones_ch2
);
   timeunit 1ns;
   timeprecision 1ps;
   // a load sees levels only, so a count of high cycles over a window is what it keeps
   always_ff @(posedge aclk) begin
      if (clr) begin
         ones_ch1 <= 16'h0000;
         ones_ch2 <= 16'h0000;
      end else begin
         ones_ch1 <= ones_ch1 + 16'(pwm_in[0]);
         ones_ch2 <= ones_ch2 + 16'(pwm_in[1]);
      end
   end
endmodule
`default_nettype wire

// ---- dps_top_bench.sv ----
// dps_top_bench: self-checking bench for dps_top, registers over AXI4-Lite.
// assumes dps_top and dps_load_model are compiled first; one 250 MHz clock.
`default_nettype none
module dps_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h00000000;
   logic [3:0] wstrb = 4'hf;
   logic awready, wready, bvalid, arready, rvalid, clr = 1'b0, idl;
   logic [1:0] bresp, rresp, pwm, rsp;
   logic [31:0] rdata, rv, w, seed = 32'hde19e775;
   logic [15:0] ones1, ones2;
   int miscompares = 0, compares = 0, m, n;
   dps_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .pwm_out(pwm));
   dps_load_model load (.aclk(aclk), .clr(clr), .pwm_in(pwm), .ones_ch1(ones1),
      .ones_ch2(ones2));
   // 4 ns period
   always #2 aclk = ~aclk;
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // high cycles in one serial period: msb first, idle level past bit 31
   function automatic int ser1(logic [31:0] x, int p, logic lvl);
      int c = 0;
      for (int i = 0; i < p; i++) begin
         c += (i < 32) ? int'(x[31 - i]) : int'(lvl);
      end
      return c;
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bit aw_ok = 1'b0;
      bit w_ok = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (!aw_ok && awready) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_ok && wready) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      bready <= 1'b1;
      do @(posedge aclk); while (!bvalid);
      rsp = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      arvalid <= 1'b1;
      araddr <= a;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      rready <= 1'b1;
      do @(posedge aclk); while (!rvalid);
      rv = rdata;
      rsp = rresp;
      rready <= 1'b0;
   endtask
   // channel off first so the spreading accumulator starts from zero
   task automatic cfg(input logic [31:0] c, input logic [31:0] p, input logic [31:0] d);
      wr(8'h00, 32'h0);
      wr(8'h10, p);
      wr(8'h14, d);
      wr(8'h20, p);
      wr(8'h24, d);
      wr(8'h00, c);
      repeat (8) @(posedge aclk);
   endtask
   task automatic cnt_clr();
      @(posedge aclk);
      clr <= 1'b1;
      @(posedge aclk);
      clr <= 1'b0;
   endtask
   task automatic measure(input int cyc);
      cnt_clr();
      repeat (cyc) @(posedge aclk);
      #1;
   endtask
   task automatic report_and_stop();
      if (miscompares == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // watchdog, about fifteen times the expected run
   initial begin
      repeat (30000) @(posedge aclk);
      miscompares++;
      report_and_stop();
   end
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      rd(8'h00);
      chk(rv, 32'h0);
      rd(8'h10);
      chk(rv, 32'h20);
      rd(8'h24);
      chk(rv, 32'h0);
      rd(8'h0c);
      chk(32'(rsp), 32'h2);
      wr(8'h0c, 32'h1);
      chk(32'(rsp), 32'h2);
      // dma_config keeps only its stored bits
      rd(8'h08);
      chk(rv, 32'h00000707);
      wr(8'h08, 32'hffffffff);
      rd(8'h08);
      chk(rv, 32'h8000ffff);
      // partial strobe: only byte lane 1 lands
      wstrb <= 4'h2;
      wr(8'h10, 32'hffffabff);
      wstrb <= 4'hf;
      rd(8'h10);
      chk(rv, 32'h0000ab20);
      // spread on channel 1, mark/space on channel 2, random invert on 2
      for (int i = 0; i < 6; i++) begin
         m = (i == 0) ? 8 : 2 + int'(rnd() % 15);
         n = (i == 0) ? 4 : (i == 1) ? m : int'(rnd() % 32'(m + 1));
         idl = 1'(rnd());
         cfg(32'h8101 | (32'(idl) << 12), m, n);
         measure(8 * m);
         chk(32'(ones1), 32'(8 * n));
         chk(32'(ones2), 32'(idl ? 8 * (m - n) : 8 * n));
      end
      // serialiser on both, mark/space bits set and ignored, channel 2 inverted
      for (int i = 0; i < 4; i++) begin
         m = (i == 0) ? 32 : 16 + int'(rnd() % 32);
         w = rnd();
         idl = 1'(rnd());
         cfg(32'h9383 | (32'(idl) << 3) | (32'(idl) << 11), m, w);
         measure(4 * m);
         chk(32'(ones1), 32'(4 * ser1(w, m, idl)));
         chk(32'(ones2), 32'(4 * (m - ser1(w, m, idl))));
      end
      // fill fifo past full, clear the error flag, then flush
      wr(8'h00, 32'h40);
      for (int i = 0; i < 64; i++) begin
         wr(8'h18, rnd());
      end
      rd(8'h04);
      chk(rv & 32'h7, 32'h1);
      wr(8'h18, 32'h0);
      rd(8'h04);
      chk(rv & 32'h7, 32'h5);
      wr(8'h04, 32'h4);
      rd(8'h04);
      chk(rv & 32'h7, 32'h1);
      rd(8'h18);
      chk(rv, 32'h0);
      wr(8'h00, 32'h40);
      rd(8'h00);
      chk(rv, 32'h0);
      rd(8'h04);
      chk(rv & 32'h7, 32'h2);
      // one fifo word resent by repeat_last_word
      w = rnd();
      wr(8'h10, 32'h20);
      wr(8'h18, w);
      wr(8'h00, 32'h27);
      measure(64);
      chk(32'(ones1), 32'(2 * $countones(w)));
      // empty fifo without repeat: idle level stands on the pin
      wr(8'h00, 32'h40);
      wr(8'h00, 32'h29);
      measure(64);
      chk(32'(ones1), 32'd64);
      // shared fifo: first word to channel 1, second to channel 2, then stop
      wr(8'h00, 32'h40);
      wr(8'h20, 32'h20);
      wr(8'h18, 32'hffff0000);
      wr(8'h18, 32'h000000ff);
      cnt_clr();
      wr(8'h00, 32'h2323);
      repeat (120) @(posedge aclk);
      #1;
      chk(32'(ones1), 32'd16);
      chk(32'(ones2), 32'd8);
      // both stopped on empty after sending: read error and both gap flags, no busy
      rd(8'h04);
      chk(rv, 32'h0000003a);
      report_and_stop();
   end
endmodule
`default_nettype wire
